// ==== rtl/kms_map.svh ====
`ifndef KMS_MAP_SVH
`define KMS_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define KMS_REG_QUEUE  3'h0
`define KMS_REG_CFG    3'h1
`define KMS_REG_DEB    3'h2
`define KMS_REG_KIRQ   3'h3
`define KMS_REG_PORTS  3'h4
`define KMS_REG_REP    3'h5
`define KMS_REG_SLEEP  3'h6
// ****************************************
// Reset values
// ****************************************
`define KMS_RST_CFG    8'h0A
`define KMS_RST_DEB    8'hFF
`define KMS_RST_KIRQ   8'h00
`define KMS_RST_PORTS  8'hFE
`define KMS_RST_REP    8'h00
`define KMS_RST_SLEEP  8'h07
// ****************************************
// Field positions and codes
// ****************************************
`define KMS_CFG_AWAKE    7
`define KMS_CFG_IRQMODE  5
`define KMS_CFG_RELEASE  3
`define KMS_CFG_AUTOWAKE 1
`define KMS_PORTS_IRQ    1
`define KMS_REP_EN       7
`define KMS_EMPTY_CODE   7'h3F
`define KMS_REPEAT_CODE  7'h7E
// ****************************************
// Timing
// ****************************************
`define KMS_CLK_MHZ      200
`define KMS_OSC_KHZ      128
`define KMS_OSC_CYC      ((`KMS_CLK_MHZ * 1000) / `KMS_OSC_KHZ)
`define KMS_TICKS_PER_MS 6'h3F
`define KMS_DEB_BASE_MS  6'h09
`define KMS_WAKE_MS      2'h2
`define KMS_REP_DLY_MIN  8'h08
`define KMS_REP_RATE_MIN 8'h04
`endif

// ==== rtl/kms_pkg.sv ====
package kms_pkg;
   // Bus slave phases
   typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_AACK, BS_WR, BS_WACK, BS_RD, BS_RACK} kms_bus_t;
   // Two-wire slave state
   typedef struct packed {
      logic [2:0] scl;
      logic [2:0] sda;
      logic       scl_f;
      logic       sda_f;
      kms_bus_t   st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic       rw;
      logic       first;
      logic [2:0] ptr;
      logic [7:0] tx;
      logic       sda_oe;
   } kms_bus_s_t;
   // Control registers
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] deb;
      logic [7:0] kirq;
      logic [7:0] ports;
      logic [7:0] rep;
      logic [7:0] sleep;
   } kms_regs_t;
endpackage

// ==== rtl/kms_key_scan.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kms_map.svh"

module kms_key_scan #(
   parameter logic [6:0] DEV_ADDR      = 7'h38, // Arbitrary value
   parameter int         FIFO_DEPTH    = 16,
   parameter int         SLEEP_STEP_MS = 1000,
   parameter int         OSC_CYC       = `KMS_OSC_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic [63:0] key_raw,
   output logic             sda_o,
   output logic             sda_oe,
   output logic [5:0]       spare_column_outputs,
   output logic [5:0]       spare_column_outputs_oe,
   output logic             key_irq_pin,
   output logic             key_irq_pin_oe,
   output logic             asleep
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int OW = $clog2(OSC_CYC + 1);

   // ****************************************
   // Parameter checks
   // ****************************************
   if (FIFO_DEPTH < 16 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two, at least 16");
   end
   if (OSC_CYC < 2 || SLEEP_STEP_MS < 1 || SLEEP_STEP_MS > 9000) begin : g_bad_time
      $error("OSC_CYC or SLEEP_STEP_MS out of range");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      kms_pkg::kms_bus_s_t             bus;
      kms_pkg::kms_regs_t              r;
      logic [63:0]                     k1;
      logic [63:0]                     k2;
      logic [63:0]                     k3;
      logic [63:0]                     kf;
      logic [63:0]                     kdb;
      logic [OW-1:0]                   osc;
      logic                            half;
      logic [5:0]                      tms;
      logic [5:0]                      dms;
      logic [5:0]                      sms;
      logic                            settled;
      logic [1:0]                      wms;
      logic [15:0]                     idle;
      logic [FIFO_DEPTH-1:0][6:0]      mem;
      logic [AW-1:0]                   head;
      logic [AW:0]                     cnt;
      logic                            rep_on;
      logic [7:0]                      rep_cnt;
      logic [4:0]                      tcnt;
      logic                            irq;
      logic [5:0]                      col_oe;
      logic                            irq_oe;
   } kms_core_t;

   kms_core_t   s_r;
   kms_core_t   s_nxt;
   logic        tick, ms, deb_cyc, ev, press, push, pop, ld0;
   logic        rep_push, tset, lvl, wr_cfg, scl_rise, scl_fall;
   logic        start, stop, awake, clr;
   logic [5:0]  dbper, idx;
   logic [5:0]  gpo_en;
   logic [63:0] kmask, kv, diff;
   logic [6:0]  pdata;
   logic [7:0]  rbyte;
   logic [3:0]  thr;

   // Lowest set bit of a key vector
   function automatic logic [5:0] kms_low(input logic [63:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) begin
            r = 6'(i);
         end
      end
      return r;
   endfunction

   // ****************************************
   // Column output enables and key mask
   // ****************************************
   for (genvar i = 0; i < 6; i++) begin : g_col
      assign gpo_en[i] = ({1'b0, s_r.r.deb[7:5]} + 4'(i)) >= 4'h6;
      assign kmask[(i+2)*8 +: 8] = gpo_en[i] ? 8'h00 : 8'hFF;
   end
   assign kmask[15:0] = 16'hFFFF;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      s_nxt    = s_r;
      tick     = 1'b0;
      ms       = 1'b0;
      deb_cyc  = 1'b0;
      push     = 1'b0;
      pop      = 1'b0;
      ld0      = 1'b0;
      rep_push = 1'b0;
      tset     = 1'b0;
      wr_cfg   = 1'b0;
      pdata    = 7'h00;
      rbyte    = 8'h00;
      awake    = s_r.r.cfg[`KMS_CFG_AWAKE];
      // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
      s_nxt.bus.scl = {s_r.bus.scl[1:0], scl_i};
      s_nxt.bus.sda = {s_r.bus.sda[1:0], sda_i};
      s_nxt.k1 = key_raw;
      s_nxt.k2 = s_r.k1;
      s_nxt.k3 = s_r.k2;
      if (s_r.bus.scl[1] == s_r.bus.scl[2]) begin
         s_nxt.bus.scl_f = s_r.bus.scl[2];
      end
      if (s_r.bus.sda[1] == s_r.bus.sda[2]) begin
         s_nxt.bus.sda_f = s_r.bus.sda[2];
      end
      s_nxt.kf = (s_r.k2 & s_r.k3) | (s_r.kf & (s_r.k2 | s_r.k3));
      scl_rise = s_nxt.bus.scl_f & ~s_r.bus.scl_f;
      scl_fall = ~s_nxt.bus.scl_f & s_r.bus.scl_f;
      start = s_r.bus.scl_f & s_nxt.bus.scl_f & s_r.bus.sda_f & ~s_nxt.bus.sda_f;
      stop  = s_r.bus.scl_f & s_nxt.bus.scl_f & ~s_r.bus.sda_f & s_nxt.bus.sda_f;

      // Read data for the current pointer, queue pops on load
      unique case (s_r.bus.ptr)
         `KMS_REG_QUEUE: begin
            if (s_r.cnt == '0) begin
               rbyte = {1'b0, `KMS_EMPTY_CODE};
            end else begin
               rbyte = {(s_r.cnt > (AW+1)'(1)) && (s_r.mem[s_r.head][5:1] != 5'h1F),
                        s_r.mem[s_r.head]};
            end
         end
         `KMS_REG_CFG:   rbyte = s_r.r.cfg;
         `KMS_REG_DEB:   rbyte = s_r.r.deb;
         `KMS_REG_KIRQ:  rbyte = s_r.r.kirq;
         `KMS_REG_PORTS: rbyte = s_r.r.ports;
         `KMS_REG_REP:   rbyte = s_r.r.rep;
         `KMS_REG_SLEEP: rbyte = s_r.r.sleep;
         default:        rbyte = 8'h00;
      endcase

      // Two-wire register slave
      unique case (s_r.bus.st)
         kms_pkg::BS_IDLE: ;
         kms_pkg::BS_ADDR, kms_pkg::BS_WR: begin
            if (scl_rise) begin
               s_nxt.bus.sh   = {s_r.bus.sh[6:0], s_r.bus.sda_f};
               s_nxt.bus.bitc = s_r.bus.bitc + 4'h1;
            end else if (scl_fall && s_r.bus.bitc == 4'h8) begin
               s_nxt.bus.bitc   = 4'h0;
               s_nxt.bus.sda_oe = 1'b1;
               s_nxt.bus.st     = kms_pkg::BS_WACK;
               if (s_r.bus.st == kms_pkg::BS_ADDR) begin
                  s_nxt.bus.rw = s_r.bus.sh[0];
                  s_nxt.bus.st = kms_pkg::BS_AACK;
                  if (s_r.bus.sh[7:1] != DEV_ADDR) begin
                     s_nxt.bus.sda_oe = 1'b0;
                     s_nxt.bus.st     = kms_pkg::BS_IDLE;
                  end
               end else if (s_r.bus.first) begin
                  s_nxt.bus.first = 1'b0;
                  s_nxt.bus.ptr   = (s_r.bus.sh > 8'h06) ? 3'h7 : s_r.bus.sh[2:0];
               end else begin
                  unique case (s_r.bus.ptr)
                     `KMS_REG_CFG: begin
                        s_nxt.r.cfg = s_r.bus.sh;
                        wr_cfg = 1'b1;
                     end
                     `KMS_REG_DEB:   s_nxt.r.deb = s_r.bus.sh;
                     `KMS_REG_KIRQ:  s_nxt.r.kirq = s_r.bus.sh;
                     `KMS_REG_PORTS: s_nxt.r.ports = s_r.bus.sh;
                     `KMS_REG_REP:   s_nxt.r.rep = s_r.bus.sh;
                     `KMS_REG_SLEEP: s_nxt.r.sleep = s_r.bus.sh;
                     default: ;
                  endcase
               end
            end
         end
         kms_pkg::BS_AACK, kms_pkg::BS_WACK, kms_pkg::BS_RACK: begin
            if (scl_rise) begin
               s_nxt.bus.sh[0] = s_r.bus.sda_f;
            end else if (scl_fall) begin
               s_nxt.bus.sda_oe = 1'b0;
               s_nxt.bus.bitc   = 4'h0;
               s_nxt.bus.st     = kms_pkg::BS_WR;
               if (s_r.bus.st == kms_pkg::BS_RACK && s_r.bus.sh[0]) begin
                  s_nxt.bus.st = kms_pkg::BS_IDLE;
               end else if (s_r.bus.st != kms_pkg::BS_WACK && s_r.bus.rw) begin
                  s_nxt.bus.tx     = rbyte;
                  s_nxt.bus.sda_oe = ~rbyte[7];
                  s_nxt.bus.bitc   = 4'h1;
                  s_nxt.bus.st     = kms_pkg::BS_RD;
                  ld0 = (s_r.bus.ptr == `KMS_REG_QUEUE);
                  pop = ld0 && (s_r.cnt != '0);
               end
            end
         end
         kms_pkg::BS_RD: begin
            if (scl_fall) begin
               if (s_r.bus.bitc == 4'h8) begin
                  s_nxt.bus.sda_oe = 1'b0;
                  s_nxt.bus.st     = kms_pkg::BS_RACK;
               end else begin
                  s_nxt.bus.tx     = {s_r.bus.tx[6:0], 1'b0};
                  s_nxt.bus.sda_oe = ~s_r.bus.tx[6];
                  s_nxt.bus.bitc   = s_r.bus.bitc + 4'h1;
               end
            end
         end
      endcase
      if (start) begin
         s_nxt.bus.st     = kms_pkg::BS_ADDR;
         s_nxt.bus.bitc   = 4'h0;
         s_nxt.bus.first  = 1'b1;
         s_nxt.bus.sda_oe = 1'b0;
      end else if (stop) begin
         s_nxt.bus.st     = kms_pkg::BS_IDLE;
         s_nxt.bus.sda_oe = 1'b0;
      end

      // 128 kHz oscillator enable halved to the 64 kHz tick, then 1 ms
      s_nxt.osc = s_r.osc + OW'(1);
      if (s_r.osc == OW'(OSC_CYC - 1)) begin
         s_nxt.osc  = '0;
         s_nxt.half = ~s_r.half;
         tick       = s_r.half;
      end
      if (tick) begin
         s_nxt.tms = s_r.tms + 6'h01;
         ms        = (s_r.tms == `KMS_TICKS_PER_MS);
      end
      dbper = 6'(s_r.r.deb[4:0]) + `KMS_DEB_BASE_MS;
      if (ms && awake) begin
         s_nxt.dms = s_r.dms + 6'h01;
         if (s_r.dms >= dbper - 6'h01) begin
            s_nxt.dms = 6'h00;
            deb_cyc   = 1'b1;
         end
      end
      if (ms && s_r.wms != 2'h0) begin
         s_nxt.wms = s_r.wms - 2'h1;
      end

      // Matrix must hold still a full debounce period
      kv = s_r.kf & kmask;
      if (s_nxt.kf != s_r.kf || !awake || s_r.wms != 2'h0) begin
         s_nxt.sms     = 6'h00;
         s_nxt.settled = 1'b0;
      end else if (ms && !s_r.settled) begin
         s_nxt.sms = s_r.sms + 6'h01;
         s_nxt.settled = (s_r.sms >= dbper - 6'h01);
      end

      // One debounced event per cycle, lowest key first
      diff  = kv ^ s_r.kdb;
      idx   = kms_low(diff);
      ev    = s_r.settled && awake && diff != 64'h0;
      press = kv[idx];
      if (ev) begin
         s_nxt.kdb[idx] = press;
         push  = press || s_r.r.cfg[`KMS_CFG_RELEASE];
         pdata = {~press, idx};
         s_nxt.rep_on  = s_r.r.rep[`KMS_REP_EN] && (s_nxt.kdb != 64'h0);
         s_nxt.rep_cnt = {1'b0, s_r.r.rep[3:0], 3'h0} + `KMS_REP_DLY_MIN;
         s_nxt.tcnt    = s_r.r.kirq[4:0];
         // Debounce cycles counted from the event itself
         s_nxt.dms     = 6'h00;
      end else begin
         if (deb_cyc && s_r.rep_on) begin
            s_nxt.rep_cnt = s_r.rep_cnt - 8'h01;
            if (s_r.rep_cnt <= 8'h01) begin
               rep_push = 1'b1;
               push     = 1'b1;
               pdata    = `KMS_REPEAT_CODE;
               s_nxt.rep_cnt = {3'h0, s_r.r.rep[6:4], 2'h0} + `KMS_REP_RATE_MIN;
            end
         end
         if (deb_cyc && s_r.tcnt != 5'h00) begin
            s_nxt.tcnt = s_r.tcnt - 5'h01;
            tset       = (s_r.tcnt == 5'h01);
         end
      end
      if (!s_r.r.rep[`KMS_REP_EN]) begin
         s_nxt.rep_on = 1'b0;
      end

      // Event queue
      if (push && s_r.cnt < (AW+1)'(FIFO_DEPTH)) begin
         s_nxt.mem[AW'(s_r.head + s_r.cnt[AW-1:0])] = pdata;
         s_nxt.cnt = s_r.cnt + (AW+1)'(1);
      end
      if (pop) begin
         s_nxt.head = s_r.head + AW'(1);
         s_nxt.cnt  = s_nxt.cnt - (AW+1)'(1);
      end

      // Autosleep and autowake, queue contents left alone
      // Idle time restarts at once while asleep, so a wake never re-sleeps on stale time
      if (kv != 64'h0 || !awake) begin
         s_nxt.idle = 16'h0000;
      end else if (ms) begin
         s_nxt.idle = s_r.idle + 16'h0001;
      end
      if (awake && s_r.r.sleep[2:0] != 3'h0 &&
          32'(s_r.idle) >= 32'(s_r.r.sleep[2:0]) * SLEEP_STEP_MS) begin
         s_nxt.r.cfg[`KMS_CFG_AWAKE] = 1'b0;
         s_nxt.rep_on = 1'b0;
      end
      if (!awake && s_r.r.cfg[`KMS_CFG_AUTOWAKE] && kv != 64'h0) begin
         s_nxt.r.cfg[`KMS_CFG_AWAKE] = 1'b1;
         s_nxt.wms = `KMS_WAKE_MS;
      end

      // Key interrupt, set wins over clear
      thr = {s_r.r.kirq[7:5], 1'b0};
      lvl = (s_r.r.kirq[7:5] != 3'h0) && (s_nxt.cnt >= (AW+1)'(thr));
      clr = s_r.r.cfg[`KMS_CFG_IRQMODE] ? (s_nxt.cnt == '0) : pop;
      s_nxt.irq = tset || lvl || (s_r.irq && !clr);
      s_nxt.irq_oe = (s_r.r.kirq == 8'h00) ? ~s_r.r.ports[`KMS_PORTS_IRQ] : s_nxt.irq;
      s_nxt.col_oe = gpo_en & ~s_r.r.ports[7:2];

      // Synchronous reset to power-up values
      if (!resetn) begin
         s_nxt         = '0;
         s_nxt.bus.scl = 3'h7;
         s_nxt.bus.sda = 3'h7;
         s_nxt.bus.scl_f = 1'b1;
         s_nxt.bus.sda_f = 1'b1;
         s_nxt.r = '{cfg: `KMS_RST_CFG, deb: `KMS_RST_DEB, kirq: `KMS_RST_KIRQ,
                     ports: `KMS_RST_PORTS, rep: `KMS_RST_REP, sleep: `KMS_RST_SLEEP};
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   // Open-drain pins only ever pull low
   assign sda_o                   = 1'b0;
   assign sda_oe                  = s_r.bus.sda_oe;
   assign spare_column_outputs    = 6'h00;
   assign spare_column_outputs_oe = s_r.col_oe;
   assign key_irq_pin             = 1'b0;
   assign key_irq_pin_oe          = s_r.irq_oe;
   assign asleep                  = ~s_r.r.cfg[`KMS_CFG_AWAKE];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_empty_code;
      (ld0 && s_r.cnt == '0) |=> (s_r.bus.tx == {1'b0, `KMS_EMPTY_CODE});
   endproperty
   a_empty_code: assert property (p_empty_code) else $error("empty read code wrong");

   property p_more_flag;
      (ld0 && s_r.cnt > (AW+1)'(1) && s_r.mem[s_r.head][5:1] != 5'h1F) |=> s_r.bus.tx[7];
   endproperty
   a_more_flag: assert property (p_more_flag) else $error("more-data flag missing");

   property p_release_gate;
      (ev && !press && !s_r.r.cfg[`KMS_CFG_RELEASE]) |-> !push;
   endproperty
   a_release_gate: assert property (p_release_gate) else $error("release queued");

   property p_repeat;
      (rep_push && !pop && s_r.cnt < (AW+1)'(FIFO_DEPTH)) |=>
         (s_r.cnt == $past(s_r.cnt) + (AW+1)'(1)) &&
         (s_r.mem[$past(s_r.head) + $past(s_r.cnt[AW-1:0])] == `KMS_REPEAT_CODE);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat code not queued");

   property p_gpo_irq;
      (s_r.r.kirq == 8'h00) |=> (key_irq_pin_oe == !$past(s_r.r.ports[`KMS_PORTS_IRQ]));
   endproperty
   a_gpo_irq: assert property (p_gpo_irq) else $error("irq pin not general output");

   property p_fifo_lvl;
      lvl |=> key_irq_pin_oe ##1 (s_r.irq || $past(pop));
   endproperty
   a_fifo_lvl: assert property (p_fifo_lvl) else $error("level irq missing");

   property p_time_irq;
      (tset && s_r.r.kirq != 8'h00) |=> key_irq_pin_oe;
   endproperty
   a_time_irq: assert property (p_time_irq) else $error("time irq missing");

   property p_read_clear;
      (pop && !s_r.r.cfg[`KMS_CFG_IRQMODE] && !tset && !lvl) |=> !s_r.irq;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("irq not cleared by read");

   property p_sleep_hold;
      (!s_r.r.cfg[`KMS_CFG_AWAKE] && !pop) |=> $stable(s_r.cnt);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("queue changed asleep");

   property p_host_wake;
      (wr_cfg && s_r.bus.sh[`KMS_CFG_AWAKE] && !awake) |=> s_r.r.cfg[`KMS_CFG_AWAKE] [*2];
   endproperty
   a_host_wake: assert property (p_host_wake) else $error("host wake ignored");

   c_repeat: cover property (rep_push);
   c_read:   cover property (ld0 && s_r.cnt != '0);
   c_wake:   cover property (!awake ##1 awake);
endmodule // kms_key_scan
`default_nettype wire

// ==== bench/kms_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Two-wire bus master in the host's place
// ********
module kms_host #(
   parameter logic [6:0] DEV_ADDR = 7'h38
) (
   input  wire logic clk_sys,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_oe,
   output var int    nacks
);
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
      nacks  = 0;
   end
   // Quarter bit time, changes just after the edge
   task automatic half();
      repeat (5) @(posedge clk_sys);
      #1;
   endtask
   // One bit, line sampled in the high phase
   task automatic sbit(input logic b, output logic r);
      sda_oe = ~b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      half();
      scl = 1'b0;
      half();
   endtask
   // Start or repeated start
   task automatic start();
      sda_oe = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_oe = 1'b1;
      half();
      scl = 1'b0;
      half();
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_oe = 1'b0;
      half();
   endtask
   // Byte out or in, ninth bit always released
   task automatic xbyte(input logic [7:0] d, input logic rdn, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         sbit(d[i], q[i]);
      end
      sbit(1'b1, a);
      if (!rdn && a !== 1'b0) begin
         nacks++;
      end
   endtask
   task automatic reg_write(input logic [2:0] p, input logic [7:0] v);
      logic [7:0] q;
      start();
      xbyte({DEV_ADDR, 1'b0}, 1'b0, q);
      xbyte({5'h00, p}, 1'b0, q);
      xbyte(v, 1'b0, q);
      stop();
   endtask
   // Single byte read, ended by a not-acknowledge
   task automatic reg_read(input logic [2:0] p, output logic [7:0] v);
      logic [7:0] q;
      start();
      xbyte({DEV_ADDR, 1'b0}, 1'b0, q);
      xbyte({5'h00, p}, 1'b0, q);
      start();
      xbyte({DEV_ADDR, 1'b1}, 1'b0, q);
      xbyte(8'hFF, 1'b1, v);
      stop();
   endtask
endmodule // kms_host
`default_nettype wire

// ==== bench/test_kms_key_scan.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kms_map.svh"
// ********
// Bench top
// ********
module test_kms_key_scan;
   localparam logic [7:0] RST [8] = '{8'h3F, `KMS_RST_CFG, `KMS_RST_DEB, `KMS_RST_KIRQ,
                                     `KMS_RST_PORTS, `KMS_RST_REP, `KMS_RST_SLEEP, 8'h00};
   localparam int D = 2304; // Nine ms in cycles at the sped-up tick
   logic        clk_sys;
   logic        resetn;
   logic        scl;
   logic        host_oe;
   logic        sda_oe;
   wire logic   sda;
   logic [63:0] key_raw;
   logic [5:0]  col_oe;
   logic        irq_oe;
   logic        asleep;
   logic [7:0]  rd;
   int          nacks;
   int          mismatches;
   int          n_compared;
   // Pulled-up data line
   assign sda = ~(host_oe | sda_oe);
   always #2.5 clk_sys = ~clk_sys;
   kms_host host_i (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(host_oe), .nacks(nacks));
   kms_key_scan #(.SLEEP_STEP_MS(1), .OSC_CYC(2)) kms_key_scan_i (
      .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl), .sda_i(sda), .key_raw(key_raw),
      .sda_o(), .sda_oe(sda_oe), .spare_column_outputs(), .spare_column_outputs_oe(col_oe),
      .key_irq_pin(), .key_irq_pin_oe(irq_oe), .asleep(asleep));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic rdchk(input logic [2:0] p, input logic [7:0] exp, input string what);
      host_i.reg_read(p, rd);
      chk(what, exp, rd);
   endtask
   // Bounded wait for a level, timeout ends the run
   task automatic wait_for(ref logic s, input logic v, input int lim, input string what);
      int k;
      k = 0;
      while (s !== v && k < lim) begin
         cyc(1);
         k++;
      end
      chk(what, {7'h00, v}, {7'h00, s});
      if (k >= lim) begin
         results();
      end
   endtask
   // Main sequence
   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      key_raw = '0;
      mismatches = 0;
      n_compared = 0;
      cyc(8);
      resetn = 1'b1;
      cyc(4);
      chk("asleep", 8'h01, {7'h00, asleep});
      chk("outputs", 8'h00, {1'b0, irq_oe, col_oe});
      for (int i = 0; i < 8; i++) begin
         rdchk(3'(i), RST[i], "reset value");
      end
      host_i.reg_write(3'h0, 8'h55);
      host_i.reg_write(3'h7, 8'h55);
      rdchk(3'h0, 8'h3F, "queue write");
      host_i.reg_write(3'h6, 8'h00);
      host_i.reg_write(3'h2, 8'h00);
      host_i.reg_write(3'h3, 8'h20);
      host_i.reg_write(3'h1, 8'h8A);
      cyc(2);
      chk("awake", 8'h00, {7'h00, asleep});
      // Two presses, level interrupt at two entries
      key_raw[9:8] = 2'b11;
      cyc(1900);
      chk("early irq", 8'h00, {7'h00, irq_oe});
      wait_for(irq_oe, 1'b1, 1000, "level irq");
      rdchk(3'h0, 8'h88, "key 8");
      chk("read clear", 8'h00, {7'h00, irq_oe});
      rdchk(3'h0, 8'h09, "key 9");
      rdchk(3'h0, 8'h3F, "empty");
      // Release with time interrupt of one debounce cycle
      host_i.reg_write(3'h3, 8'h01);
      key_raw[8] = 1'b0;
      cyc(3300);
      chk("time irq early", 8'h00, {7'h00, irq_oe});
      wait_for(irq_oe, 1'b1, 2500, "time irq");
      rdchk(3'h0, 8'h48, "release");
      // Releases off
      host_i.reg_write(3'h1, 8'h82);
      key_raw[9] = 1'b0;
      cyc(3000);
      rdchk(3'h0, 8'h3F, "no release");
      // Autosleep keeps the queue, a keypress wakes
      key_raw[10] = 1'b1;
      cyc(3000);
      key_raw[10] = 1'b0;
      host_i.reg_write(3'h6, 8'h01);
      wait_for(asleep, 1'b1, 1500, "autosleep");
      rdchk(3'h1, 8'h02, "sleep state");
      host_i.reg_write(3'h6, 8'h00);
      key_raw[11] = 1'b1;
      wait_for(asleep, 1'b0, 20, "autowake");
      cyc(512 + D + 500);
      rdchk(3'h0, 8'h8A, "kept entry");
      rdchk(3'h0, 8'h0B, "waking key");
      // General outputs, one column then all six
      host_i.reg_write(3'h3, 8'h00);
      host_i.reg_write(3'h4, 8'h54);
      host_i.reg_write(3'h2, 8'h20);
      chk("gpo one", 8'h60, {1'b0, irq_oe, col_oe});
      host_i.reg_write(3'h2, 8'hE0);
      chk("gpo all", 8'h6A, {1'b0, irq_oe, col_oe});
      rdchk(3'h4, 8'h54, "ports");
      // Autorepeat: delay 8, rate 4 debounce cycles
      host_i.reg_write(3'h5, 8'h80);
      key_raw[12] = 1'b1;
      cyc(13 * D + 1100);
      rdchk(3'h0, 8'h8C, "press");
      rdchk(3'h0, 8'h7E, "repeat 1");
      rdchk(3'h0, 8'h7E, "repeat 2");
      chk("acks", 8'h00, 8'(nacks));
      results();
   end
endmodule // test_kms_key_scan
`default_nettype wire
